// file: design/ppd_regs.sv
// phy power-state control and diagnostic result registers behind an apb slave
// assumes apb on clk_sys, strap pin asynchronous, link-side strobes on clk_sys
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/100ps
`include "ppd_map.svh"
module ppd_regs (
	input wire logic clk_sys, // system clock, 50 MHz
	input wire logic rst_n, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [13:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire logic strap_auto_pin, // bootstrap, 1 = autonomous
	input wire logic lps_negotiated, // negotiation with partner done, pulse
	input wire logic wake_request, // partner or local wake, pulse
	input wire logic link_up, // link established
	input wire logic tdr_done, // peak results valid pulse
	input wire logic [3:0] peak_type_in, // peak polarities four..one
	input wire logic [15:0] peak_loc_one, // first location word
	input wire logic [15:0] peak_loc_two, // second location word
	input wire logic snr_valid, // noise ratio valid pulse
	input wire logic [8:0] snr_in, // ten times snr in db
	input wire logic sqi_valid, // quality index valid pulse
	input wire logic [7:0] sqi_in, // quality index
	output logic autonomous_mode, // 1 autonomous, 0 managed
	output logic low_power_sleep_code, // send sleep code-groups
	output ppd_pkg::ppd_pstate_t power_state // current power state
);
	import ppd_pkg::*;
	typedef struct packed {
		ppd_pstate_t state;
		logic strap_s1;
		logic strap_s2;
		logic [1:0] strap_cnt;
		logic strap_done;
		logic autonomous;
		logic auto_cmd;
		logic auto_touched;
		logic [8:0] auto_rsv_hi;
		logic [3:0] auto_rsv_lo;
		logic sleep_en;
		logic lps_en;
		logic [13:0] pwr_rsv;
		logic sleep_req;
		logic normal_cmd;
		ppd_sel_t sel;
		logic [31:0] rdata;
	} ppd_core_t;
	ppd_core_t c_reg, c_next;
	logic setup_ph;
	logic wr_acc;
	logic rd_acc;
	logic standby_to_normal;
	logic [15:0] auto_word;
	logic [15:0] pwr_word;
	ppd_sel_t dec_sel;

	ppd_res_if res_bus();

	ppd_results u_results (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.tdr_done(tdr_done),
		.peak_type_in(peak_type_in),
		.peak_loc_one(peak_loc_one),
		.peak_loc_two(peak_loc_two),
		.snr_valid(snr_valid),
		.snr_in(snr_in),
		.sqi_valid(sqi_valid),
		.sqi_in(sqi_in),
		.link_up(link_up),
		.res(res_bus.producer)
	);

	// printed offsets are word indices, low two address bits ignored
	function automatic ppd_sel_t ppd_decode(input logic [13:0] a);
		case (a[13:2])
			`PPD_IDX_PEAK_POL: ppd_decode = PPD_SEL_PEAK;
			`PPD_IDX_AUTO_CTRL: ppd_decode = PPD_SEL_AUTO;
			`PPD_IDX_PWR_MODE: ppd_decode = PPD_SEL_PWR;
			`PPD_IDX_NOISE: ppd_decode = PPD_SEL_NOISE;
			`PPD_IDX_QUALITY: ppd_decode = PPD_SEL_QUAL;
			default: ppd_decode = PPD_SEL_NONE;
		endcase
	endfunction

	assign setup_ph = psel && !penable;
	assign pready = psel && penable;
	assign wr_acc = pready && pwrite;
	assign rd_acc = pready && !pwrite;
	assign pslverr = pready && (c_reg.sel == PPD_SEL_NONE);
	assign dec_sel = ppd_decode(paddr);

	// command bit reads 0 after first touch
	assign auto_word = {c_reg.auto_rsv_hi, c_reg.auto_cmd && !c_reg.auto_touched,
		c_reg.auto_rsv_lo, c_reg.sleep_en, c_reg.lps_en};
	assign pwr_word = {c_reg.pwr_rsv, c_reg.sleep_req, c_reg.normal_cmd};
	assign standby_to_normal = (c_reg.state == PPD_STANDBY) && (c_next.state == PPD_NORMAL);

	always_comb begin
		c_next = c_reg;
		// strap synchroniser; s1 feeds only s2
		c_next.strap_s1 = strap_auto_pin;
		c_next.strap_s2 = c_reg.strap_s1;
		if (!c_reg.strap_done) begin
			if (c_reg.strap_cnt == `PPD_STRAP_SETTLE) begin
				c_next.strap_done = 1'b1;
				c_next.autonomous = c_reg.strap_s2;
				c_next.auto_cmd = c_reg.strap_s2;
			end else begin
				c_next.strap_cnt = c_reg.strap_cnt + 2'h1;
			end
		end

		// read data registered in the setup cycle, held through access
		if (setup_ph) begin
			c_next.sel = dec_sel;
			case (dec_sel)
				PPD_SEL_PEAK: c_next.rdata = {16'h0000, res_bus.peak_word};
				PPD_SEL_AUTO: c_next.rdata = {16'h0000, auto_word};
				PPD_SEL_PWR: c_next.rdata = {16'h0000, pwr_word};
				PPD_SEL_NOISE: c_next.rdata = {16'h0000, res_bus.noise_word};
				PPD_SEL_QUAL: c_next.rdata = {16'h0000, res_bus.quality_word};
				default: c_next.rdata = 32'h0000_0000;
			endcase
		end

		if (rd_acc && c_reg.sel == PPD_SEL_AUTO) begin
			c_next.auto_touched = 1'b1;
		end
		// result registers take no writes
		if (wr_acc) begin
			case (c_reg.sel)
				PPD_SEL_AUTO: begin
					c_next.auto_touched = 1'b1;
					c_next.auto_rsv_hi = pwdata[15:`PPD_AUTO_RSV_HI_LSB];
					c_next.auto_rsv_lo = pwdata[`PPD_AUTO_RSV_LO_MSB:`PPD_AUTO_RSV_LO_LSB];
					c_next.sleep_en = pwdata[`PPD_SLEEP_EN_BIT];
					c_next.lps_en = pwdata[`PPD_LPS_EN_BIT];
					// a written 0 never drops into managed mode
					if (pwdata[`PPD_AUTO_CMD_BIT]) begin
						c_next.autonomous = 1'b1;
					end
				end
				PPD_SEL_PWR: begin
					c_next.pwr_rsv = pwdata[15:`PPD_PWR_RSV_LSB];
					c_next.sleep_req = pwdata[`PPD_SLEEP_REQ_BIT];
				end
				default: begin
				end
			endcase
		end

		case (c_reg.state)
			PPD_NORMAL: begin
				if (c_reg.sleep_req && !c_reg.normal_cmd) begin
					c_next.state = PPD_NEGOTIATE;
				end
			end
			PPD_NEGOTIATE: begin
				if (c_reg.normal_cmd || !c_reg.sleep_req) begin
					c_next.state = PPD_NORMAL;
				end else if (lps_negotiated) begin
					c_next.state = c_reg.sleep_en ? PPD_SLEEP : PPD_STANDBY;
				end
			end
			PPD_SLEEP: begin
				if (c_reg.normal_cmd || wake_request) begin
					c_next.state = PPD_NORMAL;
				end
			end
			PPD_STANDBY: begin
				if (c_reg.normal_cmd || wake_request) begin
					c_next.state = PPD_NORMAL;
				end
			end
			default: c_next.state = PPD_NORMAL;
		endcase

		// a write in the same cycle wins over the self-clear; a written 0 releases the block
		if (standby_to_normal) begin
			c_next.normal_cmd = 1'b0;
		end
		if (wr_acc && c_reg.sel == PPD_SEL_PWR) begin
			c_next.normal_cmd = pwdata[`PPD_NORMAL_CMD_BIT];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			c_reg <= '0;
			c_reg.auto_rsv_lo <= `PPD_AUTO_RSV_LO_RST;
			c_reg.sleep_en <= `PPD_SLEEP_EN_RST;
			c_reg.lps_en <= `PPD_LPS_EN_RST;
		end else begin
			c_reg <= c_next;
		end
	end

	assign prdata = c_reg.rdata;
	assign autonomous_mode = c_reg.autonomous;
	assign power_state = c_reg.state;
	// only in negotiation, and only with the enable bit set
	assign low_power_sleep_code = (c_reg.state == PPD_NEGOTIATE) && c_reg.lps_en;

	sequence s_in_negotiate;
		c_reg.state == PPD_NEGOTIATE && c_reg.sleep_req && !c_reg.normal_cmd;
	endsequence
	sequence s_negotiated;
		s_in_negotiate ##0 lps_negotiated;
	endsequence

	// code only ever follows a stored sleep request, and only with the enable bit
	a_lps_gated: assert property (@(posedge clk_sys) disable iff (!rst_n)
		low_power_sleep_code |-> c_reg.lps_en && $past(c_reg.sleep_req))
		else $error("sleep code sent without enable");
	a_sleep_target: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_negotiated |=> power_state == ($past(c_reg.sleep_en) ? PPD_SLEEP : PPD_STANDBY))
		else $error("wrong state after negotiation");
	a_sleep_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(wr_acc && c_reg.sel == PPD_SEL_PWR && pwdata[1:0] == 2'b10 && !c_reg.normal_cmd
		&& c_reg.state == PPD_NORMAL)
		|=> ##1 c_reg.state == PPD_NEGOTIATE)
		else $error("sleep request did not start negotiation");
	a_normal_force: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(c_reg.normal_cmd && c_reg.state != PPD_NORMAL) |=> c_reg.state == PPD_NORMAL)
		else $error("normal command did not force normal");
	a_normal_keep: assert property (@(posedge clk_sys) disable iff (!rst_n)
		($fell(c_reg.normal_cmd) && !$past(wr_acc && c_reg.sel == PPD_SEL_PWR))
		|-> $past(c_reg.state) == PPD_STANDBY && c_reg.state == PPD_NORMAL)
		else $error("normal command cleared outside standby exit");
	a_managed_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(c_reg.strap_done && $past(c_reg.strap_done) && $past(autonomous_mode))
		|-> autonomous_mode)
		else $error("left autonomous mode after reset");
	a_strap_take: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(c_reg.strap_done) |-> autonomous_mode == $past(c_reg.strap_s2))
		else $error("mode not taken from bootstrap");
	a_cmd_once: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(pready && c_reg.sel == PPD_SEL_AUTO) |=> ##1 auto_word[`PPD_AUTO_CMD_BIT] == 1'b0)
		else $error("autonomous command bit read back nonzero");
	a_ro_ignore: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(wr_acc && c_reg.sel == PPD_SEL_NOISE && !snr_valid)
		|=> res_bus.noise_word == $past(res_bus.noise_word))
		else $error("write changed a result register");
	a_noise_take: assert property (@(posedge clk_sys) disable iff (!rst_n)
		snr_valid |=> res_bus.noise_word == {7'h00, $past(snr_in)})
		else $error("noise result not captured");
	a_peak_pos: assert property (@(posedge clk_sys) disable iff (!rst_n)
		tdr_done |=> res_bus.peak_word[14:11] == ($past(peak_type_in)
		& {|$past(peak_loc_two[15:8]), |$past(peak_loc_two[7:0]),
		|$past(peak_loc_one[15:8]), |$past(peak_loc_one[7:0])}))
		else $error("peak polarity bits misplaced");
	a_peak_three: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(tdr_done && peak_loc_two[7:0] == 8'h00) |=> !res_bus.peak_word[13])
		else $error("peak three reported with zero location");
endmodule

// file: pkg/ppd_map.svh
// register map, field positions, reset values and timing counts of the phy power/diag block
// assumes word-indexed registers, byte address is four times the index
`ifndef PPD_MAP_SVH
`define PPD_MAP_SVH
`define PPD_IDX_PEAK_POL 12'h18A
`define PPD_IDX_AUTO_CTRL 12'h18B
`define PPD_IDX_PWR_MODE 12'h18C
`define PPD_IDX_NOISE 12'h197
`define PPD_IDX_QUALITY 12'h198
`define PPD_ADDR_W 12
`define PPD_PEAK_LSB 11
`define PPD_PEAK_MSB 14
`define PPD_AUTO_CMD_BIT 6
`define PPD_AUTO_RSV_LO_LSB 2
`define PPD_AUTO_RSV_LO_MSB 5
`define PPD_AUTO_RSV_HI_LSB 7
`define PPD_SLEEP_EN_BIT 1
`define PPD_LPS_EN_BIT 0
`define PPD_SLEEP_REQ_BIT 1
`define PPD_NORMAL_CMD_BIT 0
`define PPD_PWR_RSV_LSB 2
`define PPD_SQS_LSB 8
`define PPD_AUTO_RSV_LO_RST 4'h6
`define PPD_SLEEP_EN_RST 1'b1
`define PPD_LPS_EN_RST 1'b0
`define PPD_SQI_EXCELLENT 8'h46
`define PPD_SQI_GOOD 8'h28
`define PPD_STRAP_SETTLE 2'h2
`endif

// file: pkg/ppd_pkg.sv
// types of the phy power/diag register block
// assumes ppd_map.svh sits beside it on the include path
package ppd_pkg;
	typedef enum logic [1:0] {
		PPD_NORMAL = 2'b00,
		PPD_NEGOTIATE = 2'b01,
		PPD_SLEEP = 2'b10,
		PPD_STANDBY = 2'b11
	} ppd_pstate_t;
	typedef enum logic [2:0] {
		PPD_SEL_NONE = 3'b000,
		PPD_SEL_PEAK = 3'b001,
		PPD_SEL_AUTO = 3'b010,
		PPD_SEL_PWR = 3'b011,
		PPD_SEL_NOISE = 3'b100,
		PPD_SEL_QUAL = 3'b101
	} ppd_sel_t;
	typedef enum logic [1:0] {
		PPD_SQS_NOLINK = 2'b00,
		PPD_SQS_POOR = 2'b01,
		PPD_SQS_GOOD = 2'b10,
		PPD_SQS_EXCELLENT = 2'b11
	} ppd_sqs_t;
endpackage

// file: pkg/ppd_res_if.sv
// carries the read-only result words from the result capture to the register block
// assumes one producer and one consumer on the same clock
`timescale 1ns/100ps
interface ppd_res_if;
	logic [15:0] peak_word;
	logic [15:0] noise_word;
	logic [15:0] quality_word;
	modport producer(output peak_word, noise_word, quality_word);
	modport consumer(input peak_word, noise_word, quality_word);
endinterface

// file: design/ppd_results.sv
// captures peak polarity, noise ratio and signal quality results
// assumes measurement inputs are on clk_sys, valid strobes are one-cycle pulses
`timescale 1ns/100ps
`include "ppd_map.svh"
module ppd_results (
	input wire logic clk_sys, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic tdr_done, // peak results valid pulse
	input wire logic [3:0] peak_type_in, // 1 = negative peak, 0 = positive
	input wire logic [15:0] peak_loc_one, // first location word
	input wire logic [15:0] peak_loc_two, // second location word
	input wire logic snr_valid, // noise ratio valid pulse
	input wire logic [8:0] snr_in, // ten times snr in db
	input wire logic sqi_valid, // quality index valid pulse
	input wire logic [7:0] sqi_in, // quality index
	input wire logic link_up, // link established
	ppd_res_if.producer res // result words
);
	import ppd_pkg::*;
	typedef struct packed {
		logic [3:0] peak;
		logic [8:0] noise;
		logic [7:0] qual;
		ppd_sqs_t sqs;
	} ppd_res_state_t;
	ppd_res_state_t r_reg, r_next;
	logic [3:0] loc_nz;

	function automatic ppd_sqs_t ppd_grade(input logic up, input logic [7:0] q);
		if (!up) begin
			ppd_grade = PPD_SQS_NOLINK;
		end else if (q > `PPD_SQI_EXCELLENT) begin
			ppd_grade = PPD_SQS_EXCELLENT;
		end else if (q >= `PPD_SQI_GOOD) begin
			ppd_grade = PPD_SQS_GOOD;
		end else begin
			ppd_grade = PPD_SQS_POOR;
		end
	endfunction

	// peak order 4..1 matches loc two hi/lo, loc one hi/lo
	assign loc_nz = {|peak_loc_two[15:8], |peak_loc_two[7:0], |peak_loc_one[15:8],
		|peak_loc_one[7:0]};

	always_comb begin
		r_next = r_reg;
		if (tdr_done) begin
			r_next.peak = peak_type_in & loc_nz;
		end
		if (snr_valid) begin
			r_next.noise = snr_in;
		end
		if (sqi_valid) begin
			r_next.qual = sqi_in;
			r_next.sqs = ppd_grade(link_up, sqi_in);
		end else if (!link_up) begin
			r_next.sqs = PPD_SQS_NOLINK;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign res.peak_word = {1'b0, r_reg.peak, 11'h000};
	assign res.noise_word = {7'h00, r_reg.noise};
	assign res.quality_word = {6'h00, r_reg.sqs, r_reg.qual};

	a_peak_masked: assert property (@(posedge clk_sys) disable iff (!rst_n)
		tdr_done |=> (r_reg.peak & ~$past(loc_nz)) == 4'h0)
		else $error("peak polarity set with zero location");
	a_grade_link: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(sqi_valid && link_up && sqi_in > `PPD_SQI_EXCELLENT)
		|=> r_reg.sqs == PPD_SQS_EXCELLENT)
		else $error("quality status not excellent above threshold");
	a_nolink_sqs: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!link_up |=> r_reg.sqs == PPD_SQS_NOLINK)
		else $error("quality status shows link while down");
endmodule

// file: bench/ppd_link_partner.sv
// remote link partner: answers low-power sleep code-groups with a negotiation-done pulse
// assumes it shares clk_sys with the register block; reply delay set by the bench
`timescale 1ns/100ps
module ppd_link_partner (
	input wire logic clk_sys, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic [7:0] reply_delay, // cycles of sleep code before answering
	input wire logic low_power_sleep_code, // sleep code-groups seen on the wire
	output logic lps_negotiated // negotiation done, one-cycle pulse
);
	logic [7:0] seen_cnt;
	// answers only what it really receives, so no code means no sleep
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			seen_cnt <= 8'h00;
			lps_negotiated <= 1'b0;
		end else begin
			lps_negotiated <= low_power_sleep_code && (seen_cnt == reply_delay);
			if (!low_power_sleep_code) begin
				seen_cnt <= 8'h00;
			end else if (seen_cnt != 8'hFF) begin
				seen_cnt <= seen_cnt + 8'h01;
			end
		end
	end
endmodule

// file: bench/ppd_regs_tb.sv
// self-checking bench of the phy power/diag register block
// assumes ppd_pkg compiled first and ppd_map.svh on the include path
`timescale 1ns/100ps
`include "ppd_map.svh"
module ppd_regs_tb;
	import ppd_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [13:0] paddr = 14'h0000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic strap_auto_pin = 1'b1;
	logic lps_negotiated;
	logic wake_request = 1'b0;
	logic link_up = 1'b0;
	logic tdr_done = 1'b0;
	logic [3:0] peak_type_in = 4'h0;
	logic [15:0] peak_loc_one = 16'h0000;
	logic [15:0] peak_loc_two = 16'h0000;
	logic snr_valid = 1'b0;
	logic [8:0] snr_in = 9'h000;
	logic sqi_valid = 1'b0;
	logic [7:0] sqi_in = 8'h00;
	logic autonomous_mode;
	logic low_power_sleep_code;
	ppd_pstate_t power_state;
	logic [7:0] reply_delay = 8'h03;
	logic [31:0] rd;
	logic err;
	int mismatches = 0;
	int checked = 0;
	int cyc = 0;

	ppd_regs u_ppd_regs (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .strap_auto_pin(strap_auto_pin), .lps_negotiated(lps_negotiated),
		.wake_request(wake_request), .link_up(link_up), .tdr_done(tdr_done),
		.peak_type_in(peak_type_in), .peak_loc_one(peak_loc_one), .peak_loc_two(peak_loc_two),
		.snr_valid(snr_valid), .snr_in(snr_in), .sqi_valid(sqi_valid), .sqi_in(sqi_in),
		.autonomous_mode(autonomous_mode), .low_power_sleep_code(low_power_sleep_code),
		.power_state(power_state));
	ppd_link_partner u_ppd_link_partner (.clk_sys(clk_sys), .rst_n(rst_n),
		.reply_delay(reply_delay), .low_power_sleep_code(low_power_sleep_code),
		.lps_negotiated(lps_negotiated));

	always #10 clk_sys = ~clk_sys;

	task automatic test_done();
		if (mismatches == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// hang guard, the whole run needs a few hundred cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			test_done();
		end
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] idx, input logic [15:0] wd);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {16'h0000, wd};
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge clk_sys);
			n++;
		end
		if (pready !== 1'b1) chk("pready", 32'h1, 32'h0);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rchk(input string name, input logic [11:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 16'h0000);
		chk(name, exp, rd);
	endtask

	task automatic wst(input ppd_pstate_t s);
		int n;
		n = 0;
		while (power_state !== s && n < 100) begin
			@(posedge clk_sys);
			n++;
		end
		chk("power_state", {30'h0, s}, {30'h0, power_state});
	endtask

	// 0 peak capture, 1 noise strobe, other quality strobe
	task automatic pulse(input int which);
		case (which)
			0: tdr_done <= 1'b1;
			1: snr_valid <= 1'b1;
			default: sqi_valid <= 1'b1;
		endcase
		@(posedge clk_sys);
		tdr_done <= 1'b0;
		snr_valid <= 1'b0;
		sqi_valid <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask

	task automatic do_reset(input logic strap);
		rst_n <= 1'b0;
		strap_auto_pin <= strap;
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk_sys);
	endtask

	task automatic t_reset_values();
		do_reset(1'b1);
		chk("autonomous_mode", 32'h1, {31'h0, autonomous_mode});
		rchk("auto_first", `PPD_IDX_AUTO_CTRL, 32'h0000005A);
		rchk("auto_again", `PPD_IDX_AUTO_CTRL, 32'h0000001A);
		rchk("power_mode", `PPD_IDX_PWR_MODE, 32'h00000000);
		apb(1'b1, `PPD_IDX_AUTO_CTRL, 16'h001A);
		chk("autonomous_kept", 32'h1, {31'h0, autonomous_mode});
		do_reset(1'b0);
		chk("managed_mode", 32'h0, {31'h0, autonomous_mode});
		rchk("auto_managed", `PPD_IDX_AUTO_CTRL, 32'h0000001A);
	endtask

	task automatic t_access();
		apb(1'b1, `PPD_IDX_PEAK_POL, 16'hFFFF);
		apb(1'b1, `PPD_IDX_NOISE, 16'hFFFF);
		apb(1'b1, `PPD_IDX_QUALITY, 16'hFFFF);
		rchk("peak_ro", `PPD_IDX_PEAK_POL, 32'h00000000);
		chk("mapped_err", 32'h0, {31'h0, err});
		rchk("noise_ro", `PPD_IDX_NOISE, 32'h00000000);
		rchk("quality_ro", `PPD_IDX_QUALITY, 32'h00000000);
		apb(1'b0, 12'h000, 16'h0000);
		chk("unmapped_err", 32'h1, {31'h0, err});
		chk("unmapped_data", 32'h0, rd);
	endtask

	task automatic t_results();
		logic [7:0] qi[4];
		logic [1:0] qs[4];
		qi = '{8'h47, 8'h46, 8'h28, 8'h27};
		qs = '{2'h3, 2'h2, 2'h2, 2'h1};
		peak_type_in <= 4'hF;
		peak_loc_one <= 16'h0012;
		peak_loc_two <= 16'h3400;
		pulse(0);
		rchk("peak_masked", `PPD_IDX_PEAK_POL, 32'h00004800);
		peak_type_in <= 4'h6;
		peak_loc_one <= 16'h0101;
		peak_loc_two <= 16'h0101;
		pulse(0);
		rchk("peak_all", `PPD_IDX_PEAK_POL, 32'h00003000);
		link_up <= 1'b1;
		snr_in <= 9'h1FF;
		pulse(1);
		rchk("noise", `PPD_IDX_NOISE, 32'h000001FF);
		for (int i = 0; i < 4; i++) begin
			sqi_in <= qi[i];
			pulse(2);
			rchk("quality", `PPD_IDX_QUALITY, {22'h0, qs[i], qi[i]});
		end
		link_up <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rchk("quality_nolink", `PPD_IDX_QUALITY, 32'h00000027);
	endtask

	task automatic t_sleep();
		reply_delay <= 8'h03;
		apb(1'b1, `PPD_IDX_AUTO_CTRL, 16'h001B);
		apb(1'b1, `PPD_IDX_PWR_MODE, 16'h0002);
		wst(PPD_SLEEP);
		apb(1'b1, `PPD_IDX_PWR_MODE, 16'h0003);
		wst(PPD_NORMAL);
		rchk("normal_kept", `PPD_IDX_PWR_MODE, 32'h00000003);
		apb(1'b1, `PPD_IDX_PWR_MODE, 16'h0000);
	endtask

	// slow partner: the request must hold through a long negotiation
	task automatic t_standby();
		reply_delay <= 8'h14;
		apb(1'b1, `PPD_IDX_AUTO_CTRL, 16'h0019);
		apb(1'b1, `PPD_IDX_PWR_MODE, 16'h0002);
		repeat (2) @(posedge clk_sys);
		chk("code_sent", 32'h1, {31'h0, low_power_sleep_code});
		wst(PPD_STANDBY);
		apb(1'b1, `PPD_IDX_PWR_MODE, 16'h0001);
		wst(PPD_NORMAL);
		rchk("normal_cleared", `PPD_IDX_PWR_MODE, 32'h00000000);
	endtask

	task automatic t_no_code();
		logic seen;
		seen = 1'b0;
		apb(1'b1, `PPD_IDX_AUTO_CTRL, 16'h001A);
		apb(1'b1, `PPD_IDX_PWR_MODE, 16'h0002);
		repeat (40) begin
			@(posedge clk_sys);
			if (low_power_sleep_code !== 1'b0) seen = 1'b1;
		end
		chk("code_blocked", 32'h0, {31'h0, seen});
		wst(PPD_NEGOTIATE);
		apb(1'b1, `PPD_IDX_PWR_MODE, 16'h0000);
		wst(PPD_NORMAL);
	endtask

	initial begin
		t_reset_values();
		t_access();
		t_results();
		t_sleep();
		t_standby();
		t_no_code();
		test_done();
	end
endmodule
